// >>> design/aisc_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Converter front-end control: channel select, open-sensor and buffer
// enables, and the conversion-ready flag, on the core's register port.
// ------------------------------------------------------------------
module aisc_top
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  // Special function register port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic [7:0]      sfr_rdata_o,
  // Converter core
  input  wire logic       result_valid_i,
  input  wire logic [23:0] result_i,
  // Analog switch controls
  output logic [7:0]      pos_pin_sel_o,
  output logic            pos_common_sel_o,
  output logic [7:0]      neg_pin_sel_o,
  output logic            neg_common_sel_o,
  output logic            temp_diode_sel_o,
  output logic            open_sensor_current_enable_o,
  output logic            input_buffer_enable_o,
  output logic            conversion_ready_flag_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [7:0]  input_channel_select_reg;
  logic [7:0]  input_channel_select_next;
  logic [7:0]  converter_control_0_reg;
  logic [7:0]  converter_control_0_next;
  logic        conversion_ready_flag_reg;
  logic        conversion_ready_flag_next;
  logic [23:0] result_reg;
  logic [23:0] result_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        temp_mode;
  logic        result_read;
  logic [7:0]  pos_pin_sel;
  logic        pos_common_sel;
  logic [7:0]  neg_pin_sel;
  logic        neg_common_sel;
  logic [7:0]  pos_pin_sel_next;
  logic        pos_common_sel_next;
  logic [7:0]  neg_pin_sel_next;
  logic        neg_common_sel_next;
  logic        temp_diode_sel_next;
  logic        open_sensor_enable_next;
  logic        buffer_enable_next;

  // ------------------------------------------------------------------
  // Register writes and the ready flag
  // ------------------------------------------------------------------

  // Any result byte read counts as reading the result, so a partial read
  // still acknowledges it; the mid and high bytes stay latched meanwhile.
  assign result_read = sfr_rd_i && (sfr_addr_i == aisc_pkg::RESULT_LOW_ADDR
                                 || sfr_addr_i == aisc_pkg::RESULT_MID_ADDR
                                 || sfr_addr_i == aisc_pkg::RESULT_HIGH_ADDR);

  // A write stores all eight bits, reserved codes included.
  always_comb
  begin
    input_channel_select_next  = input_channel_select_reg;
    converter_control_0_next   = converter_control_0_reg;
    conversion_ready_flag_next = conversion_ready_flag_reg;
    result_next                = result_reg;
    if (sfr_wr_i && sfr_addr_i == aisc_pkg::INPUT_CHANNEL_SELECT_ADDR)
      input_channel_select_next = sfr_wdata_i;
    if (sfr_wr_i && sfr_addr_i == aisc_pkg::CONVERTER_CONTROL_0_ADDR)
      converter_control_0_next = sfr_wdata_i;
    if (result_read)
      conversion_ready_flag_next = 1'b0;
    // A new result wins over a read in the same cycle so none is lost.
    if (result_valid_i)
    begin
      conversion_ready_flag_next = 1'b1;
      result_next                = result_i;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      input_channel_select_reg  <= aisc_pkg::INPUT_CHANNEL_SELECT_RESET;
      converter_control_0_reg   <= aisc_pkg::CONVERTER_CONTROL_0_RESET;
      conversion_ready_flag_reg <= 1'b0;
      result_reg                <= 24'h000000;
    end
    else
    begin
      input_channel_select_reg  <= input_channel_select_next;
      converter_control_0_reg   <= converter_control_0_next;
      conversion_ready_flag_reg <= conversion_ready_flag_next;
      result_reg                <= result_next;
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------

  // Read data is registered; unmapped addresses read zero.
  always_comb
  begin
    rdata_next = 8'h00;
    case (sfr_addr_i)
      aisc_pkg::INPUT_CHANNEL_SELECT_ADDR: rdata_next = input_channel_select_reg;
      aisc_pkg::CONVERTER_CONTROL_0_ADDR:  rdata_next = converter_control_0_reg;
      aisc_pkg::AUX_INTERRUPT_ADDR:
        rdata_next[aisc_pkg::READY_BIT] = conversion_ready_flag_reg;
      aisc_pkg::RESULT_LOW_ADDR:           rdata_next = result_reg[7:0];
      aisc_pkg::RESULT_MID_ADDR:           rdata_next = result_reg[15:8];
      aisc_pkg::RESULT_HIGH_ADDR:          rdata_next = result_reg[23:16];
      default:                             rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  // ------------------------------------------------------------------
  // Multiplexer decode
  // ------------------------------------------------------------------

  // Sensor mode needs the whole byte; a lone 15 in one nibble is reserved.
  assign temp_mode = (input_channel_select_reg == aisc_pkg::TEMP_SENSOR_CODE);

  // The two nibbles decode independently, so no pairing is imposed.
  aisc_channel_decode u_pos_decode
  (
    .field_i      (input_channel_select_reg[7:aisc_pkg::POS_FIELD_LSB]),
    .temp_mode_i  (temp_mode),
    .pin_sel_o    (pos_pin_sel),
    .common_sel_o (pos_common_sel)
  );

  aisc_channel_decode u_neg_decode
  (
    .field_i      (input_channel_select_reg[3:0]),
    .temp_mode_i  (temp_mode),
    .pin_sel_o    (neg_pin_sel),
    .common_sel_o (neg_common_sel)
  );

  // ------------------------------------------------------------------
  // Switch outputs, registered so they change glitch-free
  // ------------------------------------------------------------------

  // Next switch states come from the decoders and the control bits; the
  // flop process below only copies them, so a decode change stays local.
  always_comb
  begin
    pos_pin_sel_next        = pos_pin_sel;
    pos_common_sel_next     = pos_common_sel;
    neg_pin_sel_next        = neg_pin_sel;
    neg_common_sel_next     = neg_common_sel;
    temp_diode_sel_next     = temp_mode;
    open_sensor_enable_next = converter_control_0_reg[aisc_pkg::OPEN_SENSOR_BIT];
    buffer_enable_next      = converter_control_0_reg[aisc_pkg::BUFFER_BIT];
  end

  // The analog switches see one clean edge per change, at the cost of one
  // extra cycle of latency after a write.
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pos_pin_sel_o                <= 8'h01;
      pos_common_sel_o             <= 1'b0;
      neg_pin_sel_o                <= 8'h02;
      neg_common_sel_o             <= 1'b0;
      temp_diode_sel_o             <= 1'b0;
      open_sensor_current_enable_o <= 1'b0;
      input_buffer_enable_o        <= 1'b0;
    end
    else
    begin
      pos_pin_sel_o                <= pos_pin_sel_next;
      pos_common_sel_o             <= pos_common_sel_next;
      neg_pin_sel_o                <= neg_pin_sel_next;
      neg_common_sel_o             <= neg_common_sel_next;
      temp_diode_sel_o             <= temp_diode_sel_next;
      open_sensor_current_enable_o <= open_sensor_enable_next;
      input_buffer_enable_o        <= buffer_enable_next;
    end
  end

  assign sfr_rdata_o             = rdata_reg;
  assign conversion_ready_flag_o = conversion_ready_flag_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sel_write_a: assert property (sfr_wr_i && sfr_addr_i == aisc_pkg::INPUT_CHANNEL_SELECT_ADDR
      |=> input_channel_select_reg == $past(sfr_wdata_i))
    else $error("Channel select write not stored.");
  pos_pin_a: assert property (input_channel_select_reg[7:4] < 4'h8 && !temp_mode
      |=> pos_pin_sel_o == 8'(8'h01 << $past(input_channel_select_reg[6:4])))
    else $error("Positive pin switch wrong.");
  neg_pin_a: assert property (input_channel_select_reg[3:0] < 4'h8
      |=> neg_pin_sel_o == 8'(8'h01 << $past(input_channel_select_reg[2:0])))
    else $error("Negative pin switch wrong.");
  neg_common_a: assert property (input_channel_select_reg[3:0] == 4'h8
      |=> neg_common_sel_o && neg_pin_sel_o == 8'h00)
    else $error("Negative common switch wrong.");
  temp_iso_a: assert property (temp_diode_sel_o |-> pos_pin_sel_o == 8'h00
      && neg_pin_sel_o == 8'h00 && !pos_common_sel_o && !neg_common_sel_o)
    else $error("Pins connected in sensor mode.");
  temp_exact_a: assert property (temp_diode_sel_o |-> $past(input_channel_select_reg) == 8'hff)
    else $error("Sensor mode without all-ones byte.");
  reserved_a: assert property (input_channel_select_reg[7:4] > 4'h8 && !temp_mode
      |=> pos_pin_sel_o == 8'h00 && !pos_common_sel_o)
    else $error("Reserved code connected a pin.");
  open_sensor_a: assert property (open_sensor_current_enable_o
      == $past(converter_control_0_reg[6]))
    else $error("Open-sensor enable does not follow control bit.");
  buffer_a: assert property (sfr_wr_i && sfr_addr_i == aisc_pkg::CONVERTER_CONTROL_0_ADDR
      |=> ##1 input_buffer_enable_o == $past(sfr_wdata_i[3], 2))
    else $error("Buffer enable does not follow write.");
  ready_set_a: assert property (result_valid_i |=> conversion_ready_flag_o)
    else $error("Ready flag not set by result.");
  ready_clr_a: assert property (result_read && !result_valid_i |=> !conversion_ready_flag_o)
    else $error("Ready flag not cleared by result read.");

  // Switch decode: at most one switch per input, common pin on code 8.
  pos_common_a: assert property (input_channel_select_reg[7:4] == 4'h8
      |=> pos_common_sel_o && pos_pin_sel_o == 8'h00)
    else $error("Positive common switch wrong.");
  neg_reserved_a: assert property (input_channel_select_reg[3:0] > 4'h8 && !temp_mode
      |=> neg_pin_sel_o == 8'h00 && !neg_common_sel_o)
    else $error("Reserved negative code connected a pin.");
  pos_onehot_a: assert property ($onehot0({pos_common_sel_o, pos_pin_sel_o}))
    else $error("More than one positive switch closed.");
  neg_onehot_a: assert property ($onehot0({neg_common_sel_o, neg_pin_sel_o}))
    else $error("More than one negative switch closed.");
  temp_enter_a: assert property (input_channel_select_reg == 8'hff
      |=> temp_diode_sel_o)
    else $error("All-ones byte did not select the diodes.");

  // Register storage: only a matching write may change a register.
  sel_hold_a: assert property (!(sfr_wr_i && sfr_addr_i == aisc_pkg::INPUT_CHANNEL_SELECT_ADDR)
      |=> $stable(input_channel_select_reg))
    else $error("Channel select changed without a write.");
  ctl_write_a: assert property (sfr_wr_i && sfr_addr_i == aisc_pkg::CONVERTER_CONTROL_0_ADDR
      |=> converter_control_0_reg == $past(sfr_wdata_i))
    else $error("Control write not stored.");
  ctl_hold_a: assert property (!(sfr_wr_i && sfr_addr_i == aisc_pkg::CONVERTER_CONTROL_0_ADDR)
      |=> $stable(converter_control_0_reg))
    else $error("Control register changed without a write.");
  buffer_follow_a: assert property (input_buffer_enable_o
      == $past(converter_control_0_reg[3]))
    else $error("Buffer enable does not follow control bit.");

  // Ready flag and result latch: the flag only moves on a result or a read.
  ready_hold_a: assert property (conversion_ready_flag_o && !result_read
      |=> conversion_ready_flag_o)
    else $error("Ready flag dropped without a result read.");
  ready_low_a: assert property (!conversion_ready_flag_o && !result_valid_i
      |=> !conversion_ready_flag_o)
    else $error("Ready flag rose without a result.");
  result_latch_a: assert property (result_valid_i
      |=> result_reg == $past(result_i))
    else $error("Result not latched.");

  // Read data shows the addressed register one cycle later.
  sel_read_a: assert property (sfr_addr_i == aisc_pkg::INPUT_CHANNEL_SELECT_ADDR
      |=> sfr_rdata_o == $past(input_channel_select_reg))
    else $error("Channel select read wrong.");
  ctl_read_a: assert property (sfr_addr_i == aisc_pkg::CONVERTER_CONTROL_0_ADDR
      |=> sfr_rdata_o == $past(converter_control_0_reg))
    else $error("Control register read wrong.");
  aux_read_a: assert property (sfr_addr_i == aisc_pkg::AUX_INTERRUPT_ADDR
      |=> sfr_rdata_o == {2'b00, $past(conversion_ready_flag_reg), 5'b00000})
    else $error("Ready flag read wrong.");
  low_read_a: assert property (sfr_addr_i == aisc_pkg::RESULT_LOW_ADDR
      |=> sfr_rdata_o == $past(result_reg[7:0]))
    else $error("Result low byte read wrong.");
  high_read_a: assert property (sfr_addr_i == aisc_pkg::RESULT_HIGH_ADDR
      |=> sfr_rdata_o == $past(result_reg[23:16]))
    else $error("Result high byte read wrong.");

  // Scenarios worth seeing in a run.
  temp_cov: cover property (temp_diode_sel_o);
  common_cov: cover property (pos_common_sel_o && neg_pin_sel_o != 8'h00);
  race_cov: cover property (result_valid_i && result_read);
  open_cov: cover property (open_sensor_current_enable_o && input_buffer_enable_o);
  neg_common_cov: cover property (neg_common_sel_o && pos_pin_sel_o != 8'h00);

endmodule

// >>> design/aisc_pkg.sv
package aisc_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] INPUT_CHANNEL_SELECT_ADDR = 8'hd7;
  localparam logic [7:0] CONVERTER_CONTROL_0_ADDR  = 8'hdc;
  localparam logic [7:0] AUX_INTERRUPT_ADDR        = 8'ha6;
  localparam logic [7:0] RESULT_LOW_ADDR           = 8'hd9;
  localparam logic [7:0] RESULT_MID_ADDR           = 8'hda;
  localparam logic [7:0] RESULT_HIGH_ADDR          = 8'hdb;

  // ------------------------------------------------------------------
  // Reset values and fields
  // ------------------------------------------------------------------
  localparam logic [7:0] INPUT_CHANNEL_SELECT_RESET = 8'h01;
  localparam logic [7:0] CONVERTER_CONTROL_0_RESET  = 8'h00;
  localparam logic [7:0] TEMP_SENSOR_CODE           = 8'hff;
  localparam int         POS_FIELD_LSB              = 4;
  localparam int         OPEN_SENSOR_BIT            = 6;
  localparam int         BUFFER_BIT                 = 3;
  localparam int         READY_BIT                  = 5;
  localparam logic [3:0] COMMON_PIN_CODE            = 4'h8;
  localparam int         PIN_COUNT                  = 8;

endpackage

// >>> design/aisc_channel_decode.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// One nibble of the channel select register turned into pin switches.
// ------------------------------------------------------------------
module aisc_channel_decode
(
  // Selection
  input  wire logic [3:0] field_i,
  input  wire logic       temp_mode_i,
  // Switches
  output logic [7:0]      pin_sel_o,
  output logic            common_sel_o
);

  // Pins connect only outside sensor mode; reserved codes connect nothing.
  always_comb
  begin
    pin_sel_o    = 8'h00;
    common_sel_o = 1'b0;
    if (!temp_mode_i)
    begin
      if (field_i < 4'(aisc_pkg::PIN_COUNT))
        pin_sel_o[field_i[2:0]] = 1'b1;
      else if (field_i == aisc_pkg::COMMON_PIN_CODE)
        common_sel_o = 1'b1;
      // Codes 9..15 fall through with every switch open.
    end
  end

endmodule

// >>> verification/aisc_result_source.sv
`timescale 1ns/1ps
// ----------
// Converter core stand-in that hands results to the block.
// ----------
module aisc_result_source
(
  // Clock
  input  wire logic        mclk_i,
  // Result side
  output logic             result_valid_o,
  output logic [23:0]      result_o
);
  initial result_valid_o = 1'b0;
  initial result_o = 24'h000000;

  // One-cycle result pulse; the bus is inverted afterwards so stale data never looks valid.
  task automatic send(input logic [23:0] v);
    @(negedge mclk_i);
    result_valid_o = 1'b1;
    result_o = v;
    @(negedge mclk_i);
    result_valid_o = 1'b0;
    result_o = ~v;
  endtask
endmodule

// >>> verification/tb_adc_input_select_control.sv
`timescale 1ns/1ps
module tb_adc_input_select_control;
  // ----------
  // Signals
  // ----------
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  sfr_addr_i = 8'h00;
  logic        sfr_wr_i = 1'b0;
  logic        sfr_rd_i = 1'b0;
  logic [7:0]  sfr_wdata_i = 8'h00;
  logic [7:0]  sfr_rdata_o;
  logic        result_valid_i;
  logic [23:0] result_i;
  logic [7:0]  pos_pin_sel_o, neg_pin_sel_o;
  logic        pos_common_sel_o, neg_common_sel_o, temp_diode_sel_o;
  logic        open_sensor_current_enable_o, input_buffer_enable_o, conversion_ready_flag_o;
  int          errors = 0;
  int          checks_done = 0;

  // Free-running system clock at 125 MHz.
  always #4 mclk_i = ~mclk_i;

  aisc_top dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .result_valid_i(result_valid_i), .result_i(result_i),
    .pos_pin_sel_o(pos_pin_sel_o), .pos_common_sel_o(pos_common_sel_o),
    .neg_pin_sel_o(neg_pin_sel_o), .neg_common_sel_o(neg_common_sel_o),
    .temp_diode_sel_o(temp_diode_sel_o),
    .open_sensor_current_enable_o(open_sensor_current_enable_o),
    .input_buffer_enable_o(input_buffer_enable_o),
    .conversion_ready_flag_o(conversion_ready_flag_o));

  aisc_result_source src (.mclk_i(mclk_i), .result_valid_o(result_valid_i),
    .result_o(result_i));

  // ----------
  // Access tasks
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Strobes last one cycle, so one edge takes exactly one access.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge mclk_i);
    sfr_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge mclk_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask

  task automatic do_reset();
    reset_n_i = 1'b0;
    repeat (5) @(negedge mclk_i);
    reset_n_i = 1'b1;
  endtask

  // Expected common bit and one-hot pins for one nibble code.
  function automatic logic [8:0] sel(input logic [3:0] c);
    return {c == 4'h8, (c < 4'h8) ? (8'h01 << c) : 8'h00};
  endfunction

  task automatic end_of_test();
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Guard against a hung run.
  initial
  begin
    #200000;
    errors++;
    end_of_test();
  end

  // ----------
  // Main sequence
  // ----------
  initial
  begin
    logic [7:0]  d;
    logic [3:0]  p, n;
    logic [23:0] v;
    logic [7:0]  ctl [3];
    ctl = '{8'h48, 8'h40, 8'h08};
    do_reset();
    rd(8'hd7, d);
    check(d, 8'h01);
    check({pos_pin_sel_o, neg_pin_sel_o}, 16'h0102);
    // Codes 0 to 8 on both nibbles, paired in opposite order.
    for (int i = 0; i < 9; i++)
    begin
      p = i[3:0];
      n = 4'h8 - p;
      wr(8'hd7, {p, n});
      repeat (2) @(negedge mclk_i);
      check({pos_common_sel_o, pos_pin_sel_o}, sel(p));
      check({neg_common_sel_o, neg_pin_sel_o}, sel(n));
    end
    wr(8'hd7, 8'h9f);
    repeat (2) @(negedge mclk_i);
    check({temp_diode_sel_o, pos_common_sel_o, pos_pin_sel_o, neg_common_sel_o,
      neg_pin_sel_o}, 0);
    rd(8'hd7, d);
    check(d, 8'h9f);
    wr(8'hd7, 8'hff);
    repeat (2) @(negedge mclk_i);
    check({temp_diode_sel_o, pos_pin_sel_o, neg_pin_sel_o}, 17'h10000);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'hdc, ctl[i]);
      repeat (2) @(negedge mclk_i);
      check({open_sensor_current_enable_o, input_buffer_enable_o},
        {ctl[i][6], ctl[i][3]});
    end
    // Unmapped place reads zero and a stray write leaves the select alone.
    wr(8'h00, 8'h5a);
    rd(8'h00, d);
    check(d, 8'h00);
    rd(8'hd7, d);
    check(d, 8'hff);
    // Four results taken and discarded, as software does after calibration.
    for (int k = 0; k < 4; k++)
    begin
      v = 24'habcdef ^ k;
      src.send(v);
      check(conversion_ready_flag_o, 1'b1);
      rd(8'ha6, d);
      check(d & 8'h20, 8'h20);
      rd(8'hd9, d);
      check({conversion_ready_flag_o, d}, {1'b0, v[7:0]});
    end
    rd(8'hda, d);
    check(d, v[15:8]);
    rd(8'hdb, d);
    check(d, v[23:16]);
    // A new result in the same cycle as a result read keeps the flag.
    fork
      src.send(24'h123456);
      rd(8'hd9, d);
    join
    check(conversion_ready_flag_o, 1'b1);
    rd(8'hdb, d);
    check(conversion_ready_flag_o, 1'b0);
    wr(8'ha6, 8'hff);
    rd(8'ha6, d);
    check(d & 8'h20, 8'h00);
    // A second reset in mid-run restores the defaults.
    do_reset();
    rd(8'hd7, d);
    check(d, 8'h01);
    rd(8'hdc, d);
    check({d, input_buffer_enable_o}, 9'h000);
    end_of_test();
  end
endmodule
